// >>> vfcd_consts.svh
`ifndef VFCD_CONSTS_SVH
`define VFCD_CONSTS_SVH
// Word 0 field positions
`define VFCD_W0_BUF_LSB 8
`define VFCD_W0_BUF_MSB 15
`define VFCD_W0_SRC_LSB 16
`define VFCD_W0_SRC_MSB 22
`define VFCD_W0_SOURCE_RELATIVE_FLAG_BIT 23
`define VFCD_W0_SRC_SEL_LSB 24
`define VFCD_W0_SRC_SEL_MSB 25
`define VFCD_W0_SEM_FMT_BIT 26
// Word 1 field positions, direct and semantic forms
`define VFCD_W1_DST_LSB 0
`define VFCD_W1_DST_MSB 6
`define VFCD_W1_DESTINATION_RELATIVE_FLAG_BIT 7
`define VFCD_W1_SEM_LSB 0
`define VFCD_W1_SEM_MSB 7
`define VFCD_W1_DSEL_LSB 9
`define VFCD_DSEL_W 3
// Word 2 field positions
`define VFCD_W2_OFS_LSB 0
`define VFCD_W2_OFS_MSB 15
`define VFCD_W2_ALT_BIT 19
// Destination select codes
`define VFCD_DSEL_ZERO 3'h4
`define VFCD_DSEL_ONE 3'h5
`define VFCD_DSEL_MASK 3'h7
// Longest clause the issuer may send
`define VFCD_MAX_CLAUSE 5'h10
`endif

// >>> vfcd_pkg.sv
package vfcd_pkg;
  // Clause kinds offered by the sequencer
  typedef enum logic [1:0] {
    VFCD_OP_OTHER,
    VFCD_OP_VERTEX_CACHE,
    VFCD_OP_TEXTURE_CACHE
  } vfcd_clause_op_t;
  // Shader stage owning a constant buffer bank
  typedef enum logic [1:0] {
    VFCD_STAGE_EARLY_VERTEX,
    VFCD_STAGE_GEOMETRY,
    VFCD_STAGE_VERTEX,
    VFCD_STAGE_PIXEL
  } vfcd_stage_t;
  // Decoder sequencing states
  typedef enum logic {
    VFCD_IDLE,
    VFCD_RUN
  } vfcd_state_t;
endpackage

// >>> vfcd_decoder.sv
`timescale 1ns/1ns
`include "vfcd_consts.svh"
// Contract
// - Only vertex/texture cache clause ops start clauses
// - Semantic fetch destination comes from table
// - Direct fetch destination comes from instruction
// - Buffer select and offset come from instruction
// - Source index optionally offset by loop index
// - Destination index optionally offset by loop index
// - Fetch index taken from named source element
// - Element selects pick fetched, 0.0, 1.0, mask
// - Whole clause runs under one launch condition
// - Instruction is four words, top one padding
// - Alternate flag swaps geometry and vertex banks
module vfcd_decoder #(
  parameter int REG_W = 7,
  parameter int LOOP_W = 8,
  parameter int SEM_DEPTH = 256
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clause_start,
  input wire vfcd_pkg::vfcd_clause_op_t clause_op,
  input wire logic [4:0] clause_count,
  input wire logic clause_cond,
  input wire vfcd_pkg::vfcd_stage_t clause_stage,
  input wire logic [LOOP_W-1:0] loop_index,
  input wire logic instr_valid,
  input wire logic [127:0] instr_word,
  output logic instr_ready,
  input wire logic sem_wr_en,
  input wire logic [7:0] sem_wr_index,
  input wire logic [REG_W-1:0] sem_wr_reg,
  output logic busy,
  output logic clause_done,
  output logic fetch_valid,
  output logic [REG_W-1:0] source_register_index,
  output logic [1:0] source_element_select,
  output logic [REG_W-1:0] destination_register_index,
  output logic [11:0] destination_element_selects,
  output logic [3:0] element_write_enable,
  output logic [7:0] constant_buffer_select,
  output vfcd_pkg::vfcd_stage_t constant_bank_stage,
  output logic [15:0] fetch_offset
);

  // Semantic table, written by the setup port
  logic [REG_W-1:0] sem_table [SEM_DEPTH];

  // Sequencer state
  vfcd_pkg::vfcd_state_t state_q, state_d;
  logic [4:0] remain_q, remain_d; // Fetches still owed in the clause
  logic cond_q, cond_d; // Launch condition held for the clause
  vfcd_pkg::vfcd_stage_t stage_q, stage_d;
  logic done_q, done_d;

  // Decoded fetch outputs
  logic fv_q, fv_d;
  logic [REG_W-1:0] src_q, src_d;
  logic [1:0] ssel_q, ssel_d;
  logic [REG_W-1:0] dst_q, dst_d;
  logic [11:0] dsel_q, dsel_d;
  logic [3:0] wen_q, wen_d;
  logic [7:0] buf_q, buf_d;
  vfcd_pkg::vfcd_stage_t bank_q, bank_d;
  logic [15:0] ofs_q, ofs_d;

  // Instruction words; the top word is padding and left unread
  logic [31:0] w0, w1, w2;
  logic take;
  logic [3:0] elem_wen;

  assign w0 = instr_word[31:0];
  assign w1 = instr_word[63:32];
  assign w2 = instr_word[95:64];
  assign take = instr_valid && instr_ready;

  // Loop-relative index, wrapping inside the register file
  function automatic logic [REG_W-1:0] rel_index(input logic [REG_W-1:0] base,
                                                 input logic rel,
                                                 input logic [LOOP_W-1:0] li);
    logic [REG_W-1:0] sum;
    sum = base;
    if (rel) begin
      sum = REG_W'(base + li[REG_W-1:0]);
    end
    return sum;
  endfunction

  // Swap geometry with early/vertex stage banks when asked
  function automatic vfcd_pkg::vfcd_stage_t alt_bank(input vfcd_pkg::vfcd_stage_t st,
                                                     input logic alt);
    vfcd_pkg::vfcd_stage_t res;
    res = st;
    if (alt) begin
      case (st)
        vfcd_pkg::VFCD_STAGE_EARLY_VERTEX: res = vfcd_pkg::VFCD_STAGE_GEOMETRY;
        vfcd_pkg::VFCD_STAGE_VERTEX: res = vfcd_pkg::VFCD_STAGE_GEOMETRY;
        vfcd_pkg::VFCD_STAGE_GEOMETRY: res = vfcd_pkg::VFCD_STAGE_VERTEX;
        default: res = st; // Other stages share nothing
      endcase
    end
    return res;
  endfunction

  // Per-element write enable: mask code suppresses the write
  generate
    for (genvar e = 0; e < 4; e++) begin : g_elem
      assign elem_wen[e] =
        w1[`VFCD_W1_DSEL_LSB + e*`VFCD_DSEL_W +: `VFCD_DSEL_W] != `VFCD_DSEL_MASK;
    end
  endgenerate

  // Ready only while the clause still owes instructions
  always_comb begin
    instr_ready = (state_q == vfcd_pkg::VFCD_RUN) && (remain_q != 5'h00);
  end

  // Semantic table write
  always_ff @(posedge core_clk) begin
    if (sem_wr_en) begin
      sem_table[sem_wr_index] <= sem_wr_reg;
    end
  end

  // Clause sequencing next state
  always_comb begin
    state_d = state_q;
    remain_d = remain_q;
    cond_d = cond_q;
    stage_d = stage_q;
    done_d = 1'b0;
    case (state_q)
      vfcd_pkg::VFCD_IDLE: begin
        // Other clause kinds belong to other engines
        if (clause_start && (clause_op == vfcd_pkg::VFCD_OP_VERTEX_CACHE ||
                             clause_op == vfcd_pkg::VFCD_OP_TEXTURE_CACHE)) begin
          state_d = vfcd_pkg::VFCD_RUN;
          // Overlong counts are cut; issuer should never send them
          remain_d = (clause_count > `VFCD_MAX_CLAUSE) ? `VFCD_MAX_CLAUSE : clause_count;
          cond_d = clause_cond;
          stage_d = clause_stage;
        end
      end
      vfcd_pkg::VFCD_RUN: begin
        if (remain_q == 5'h00) begin
          state_d = vfcd_pkg::VFCD_IDLE;
          done_d = 1'b1;
        end else if (take) begin
          remain_d = remain_q - 5'h01;
        end
      end
      default: state_d = vfcd_pkg::VFCD_IDLE;
    endcase
  end

  // Clause sequencing registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= vfcd_pkg::VFCD_IDLE;
      remain_q <= 5'h00;
      cond_q <= 1'b0;
      stage_q <= vfcd_pkg::VFCD_STAGE_EARLY_VERTEX;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      remain_q <= remain_d;
      cond_q <= cond_d;
      stage_q <= stage_d;
      done_q <= done_d;
    end
  end

  // Fetch decode next values; fields hold between fetches
  always_comb begin
    fv_d = 1'b0;
    src_d = src_q;
    ssel_d = ssel_q;
    dst_d = dst_q;
    dsel_d = dsel_q;
    wen_d = wen_q;
    buf_d = buf_q;
    bank_d = bank_q;
    ofs_d = ofs_q;
    if (take) begin
      // A failed clause condition drops every fetch of the clause
      fv_d = cond_q;
      src_d = rel_index(w0[`VFCD_W0_SRC_MSB:`VFCD_W0_SRC_LSB],
                        w0[`VFCD_W0_SOURCE_RELATIVE_FLAG_BIT], loop_index);
      ssel_d = w0[`VFCD_W0_SRC_SEL_MSB:`VFCD_W0_SRC_SEL_LSB];
      if (w0[`VFCD_W0_SEM_FMT_BIT]) begin
        dst_d = sem_table[w1[`VFCD_W1_SEM_MSB:`VFCD_W1_SEM_LSB]];
      end else begin
        dst_d = rel_index(w1[`VFCD_W1_DST_MSB:`VFCD_W1_DST_LSB],
                          w1[`VFCD_W1_DESTINATION_RELATIVE_FLAG_BIT], loop_index);
      end
      dsel_d = w1[`VFCD_W1_DSEL_LSB +: 12];
      wen_d = elem_wen;
      buf_d = w0[`VFCD_W0_BUF_MSB:`VFCD_W0_BUF_LSB];
      ofs_d = w2[`VFCD_W2_OFS_MSB:`VFCD_W2_OFS_LSB];
      bank_d = alt_bank(stage_q, w2[`VFCD_W2_ALT_BIT]);
    end
  end

  // Fetch decode registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fv_q <= 1'b0;
      src_q <= '0;
      ssel_q <= 2'h0;
      dst_q <= '0;
      dsel_q <= 12'h000;
      wen_q <= 4'h0;
      buf_q <= 8'h00;
      bank_q <= vfcd_pkg::VFCD_STAGE_EARLY_VERTEX;
      ofs_q <= 16'h0000;
    end else begin
      fv_q <= fv_d;
      src_q <= src_d;
      ssel_q <= ssel_d;
      dst_q <= dst_d;
      dsel_q <= dsel_d;
      wen_q <= wen_d;
      buf_q <= buf_d;
      bank_q <= bank_d;
      ofs_q <= ofs_d;
    end
  end

  assign busy = (state_q == vfcd_pkg::VFCD_RUN);
  assign clause_done = done_q;
  assign fetch_valid = fv_q;
  assign source_register_index = src_q;
  assign source_element_select = ssel_q;
  assign destination_register_index = dst_q;
  assign destination_element_selects = dsel_q;
  assign element_write_enable = wen_q;
  assign constant_buffer_select = buf_q;
  assign constant_bank_stage = bank_q;
  assign fetch_offset = ofs_q;

  // Helper: fetches taken in the current clause
  logic [4:0] taken_cnt_q;
  always_ff @(posedge core_clk) begin
    if (srst || !busy) begin
      taken_cnt_q <= 5'h00;
    end else if (take) begin
      taken_cnt_q <= taken_cnt_q + 5'h01;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  AST_START_ONLY_CACHE_OPS: assert property (
    !busy && clause_start && clause_op == vfcd_pkg::VFCD_OP_OTHER |=> !busy)
    else $error("non cache clause op started a clause");
  AST_VALID_NEEDS_TAKE: assert property (
    fetch_valid |-> $past(take) && $past(cond_q))
    else $error("fetch issued without taken instruction under true condition");
  AST_CLAUSE_LIMIT: assert property (
    taken_cnt_q <= `VFCD_MAX_CLAUSE)
    else $error("clause took more than sixteen fetches");
  AST_SRC_INDEX: assert property (
    take |=> source_register_index == REG_W'($past(w0[`VFCD_W0_SRC_MSB:`VFCD_W0_SRC_LSB])
      + ($past(w0[`VFCD_W0_SOURCE_RELATIVE_FLAG_BIT]) ? $past(loop_index[REG_W-1:0]) : '0)))
    else $error("source index wrong");
  AST_DST_DIRECT: assert property (
    take && !w0[`VFCD_W0_SEM_FMT_BIT] && !w1[`VFCD_W1_DESTINATION_RELATIVE_FLAG_BIT]
      |=> destination_register_index == $past(w1[`VFCD_W1_DST_MSB:`VFCD_W1_DST_LSB]))
    else $error("direct destination wrong");
  AST_DST_SEMANTIC: assert property (
    take && w0[`VFCD_W0_SEM_FMT_BIT] && !sem_wr_en
      |=> destination_register_index == sem_table[$past(w1[7:0])])
    else $error("semantic destination wrong");
  AST_BUF_OFFSET: assert property (
    take |=> constant_buffer_select == $past(w0[15:8]) && fetch_offset == $past(w2[15:0]))
    else $error("buffer select or offset wrong");
  AST_MASK_ELEM_X: assert property (
    take && w1[11:9] == `VFCD_DSEL_MASK |=> !element_write_enable[0])
    else $error("masked element still written");
  AST_ALT_GEOMETRY: assert property (
    take && w2[`VFCD_W2_ALT_BIT] && stage_q == vfcd_pkg::VFCD_STAGE_GEOMETRY
      |=> constant_bank_stage == vfcd_pkg::VFCD_STAGE_VERTEX)
    else $error("geometry stage not redirected");
  AST_SRC_ELEM: assert property (
    take |=> source_element_select == $past(w0[25:24]))
    else $error("source element select wrong");

  COV_FULL_CLAUSE: cover property (taken_cnt_q == `VFCD_MAX_CLAUSE);
  COV_SEMANTIC: cover property (take && w0[`VFCD_W0_SEM_FMT_BIT]);
  COV_FALSE_COND: cover property (take && !cond_q);
  COV_ALT: cover property (take && w2[`VFCD_W2_ALT_BIT]);
endmodule

// >>> vfcd_seq_model.sv
`timescale 1ns/1ns
// Sequencer model: launches clauses and feeds instructions
module vfcd_seq_model (
  input wire logic core_clk,
  input wire logic instr_ready,
  output vfcd_pkg::vfcd_clause_op_t clause_op,
  output logic clause_start,
  output logic [4:0] clause_count,
  output logic clause_cond,
  output vfcd_pkg::vfcd_stage_t clause_stage,
  output logic [7:0] loop_index,
  output logic instr_valid,
  output logic [127:0] instr_word
);
  // Clause program, filled by the bench; at most sixteen entries
  logic [127:0] prog [16];
  initial begin
    clause_start = 1'b0;
    clause_op = vfcd_pkg::VFCD_OP_OTHER;
    clause_count = 5'h00;
    clause_cond = 1'b1;
    clause_stage = vfcd_pkg::VFCD_STAGE_EARLY_VERTEX;
    loop_index = 8'h00;
    instr_valid = 1'b0;
    instr_word = 128'h0;
  end
  // One launch, then instructions; gap idles before each one
  task automatic run(input vfcd_pkg::vfcd_clause_op_t op, input logic [4:0] cnt,
                     input logic cond, input vfcd_pkg::vfcd_stage_t stg,
                     input logic [7:0] li, input int gap);
    int t;
    @(negedge core_clk);
    clause_op = op;
    clause_count = cnt;
    clause_cond = cond;
    clause_stage = stg;
    loop_index = li;
    clause_start = 1'b1;
    @(negedge core_clk);
    clause_start = 1'b0;
    for (int k = 0; k < cnt; k++) begin
      // Released word shows garbage, never the old value
      if (gap > 0) begin
        instr_valid = 1'b0;
        instr_word = ~instr_word;
        repeat (gap) @(negedge core_clk);
      end
      instr_word = prog[k];
      instr_valid = 1'b1;
      t = 0;
      while (instr_ready !== 1'b1 && t < 50) begin
        @(negedge core_clk);
        t++;
      end
      // Take happens at the rising edge inside this wait
      @(negedge core_clk);
    end
    instr_valid = 1'b0;
    instr_word = ~instr_word;
  endtask
endmodule

// >>> tb_vertex_fetch_clause_decoder.sv
`timescale 1ns/1ns
module tb_vertex_fetch_clause_decoder;
  localparam vfcd_pkg::vfcd_clause_op_t OPV = vfcd_pkg::VFCD_OP_VERTEX_CACHE;
  localparam vfcd_pkg::vfcd_clause_op_t OPT = vfcd_pkg::VFCD_OP_TEXTURE_CACHE;
  localparam vfcd_pkg::vfcd_stage_t ST_E = vfcd_pkg::VFCD_STAGE_EARLY_VERTEX;
  localparam vfcd_pkg::vfcd_stage_t ST_G = vfcd_pkg::VFCD_STAGE_GEOMETRY;
  localparam vfcd_pkg::vfcd_stage_t ST_V = vfcd_pkg::VFCD_STAGE_VERTEX;
  localparam vfcd_pkg::vfcd_stage_t ST_P = vfcd_pkg::VFCD_STAGE_PIXEL;
  // One row: launch values, word, expected indices and bank
  typedef struct {
    vfcd_pkg::vfcd_clause_op_t op;
    vfcd_pkg::vfcd_stage_t stg;
    logic [7:0] li;
    logic [127:0] w;
    logic [6:0] esrc;
    logic [6:0] edst;
    vfcd_pkg::vfcd_stage_t estg;
  } vfcd_row_t;
  vfcd_row_t rows [6];
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic sem_wr_en = 1'b0;
  logic [7:0] sem_wr_index = 8'h00;
  logic [6:0] sem_wr_reg = 7'h00;
  wire vfcd_pkg::vfcd_clause_op_t clause_op;
  wire vfcd_pkg::vfcd_stage_t clause_stage;
  wire vfcd_pkg::vfcd_stage_t constant_bank_stage;
  wire clause_start, clause_cond, instr_valid, instr_ready, busy, clause_done, fetch_valid;
  wire [4:0] clause_count;
  wire [7:0] loop_index, constant_buffer_select;
  wire [127:0] instr_word;
  wire [6:0] source_register_index, destination_register_index;
  wire [1:0] source_element_select;
  wire [11:0] destination_element_selects;
  wire [3:0] element_write_enable;
  wire [15:0] fetch_offset;
  logic [57:0] expq [$];
  int fails = 0;
  int n_compared = 0;
  int n_fetch = 0;
  int f0;
  vfcd_seq_model seq_u (.core_clk(core_clk), .instr_ready(instr_ready), .clause_op(clause_op),
    .clause_start(clause_start), .clause_count(clause_count), .clause_cond(clause_cond),
    .clause_stage(clause_stage), .loop_index(loop_index), .instr_valid(instr_valid),
    .instr_word(instr_word));
  vfcd_decoder dut_u (.core_clk(core_clk), .srst(srst), .clause_start(clause_start),
    .clause_op(clause_op), .clause_count(clause_count), .clause_cond(clause_cond),
    .clause_stage(clause_stage), .loop_index(loop_index), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready), .sem_wr_en(sem_wr_en),
    .sem_wr_index(sem_wr_index), .sem_wr_reg(sem_wr_reg), .busy(busy),
    .clause_done(clause_done), .fetch_valid(fetch_valid),
    .source_register_index(source_register_index), .source_element_select(source_element_select),
    .destination_register_index(destination_register_index),
    .destination_element_selects(destination_element_selects),
    .element_write_enable(element_write_enable), .constant_buffer_select(constant_buffer_select),
    .constant_bank_stage(constant_bank_stage), .fetch_offset(fetch_offset));
  // Free-running core clock, 50 ns
  initial forever #25 core_clk = ~core_clk;
  // Padding word is deliberately nonzero
  function automatic logic [127:0] mk(logic sem, logic [1:0] ss, logic sr, logic [6:0] src,
      logic [7:0] bf, logic [7:0] d8, logic [11:0] ds, logic alt, logic [15:0] ofs);
    return {32'hA5A55A5A, 12'h000, alt, 3'h0, ofs, 11'h000, ds, 1'b0, d8,
            5'h00, sem, ss, sr, src, bf, 8'h00};
  endfunction
  // Expected field bundle; a mask code clears its write enable
  function automatic logic [57:0] ex(logic [127:0] w, logic [6:0] s, logic [6:0] d,
      vfcd_pkg::vfcd_stage_t g);
    logic [3:0] we;
    for (int i = 0; i < 4; i++) we[i] = (w[41+3*i +: 3] != 3'h7);
    return {s, w[25:24], d, w[52:41], we, w[15:8], g, w[79:64]};
  endfunction
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s exp=%h seen=%h", nm, exp, seen);
    end
  endtask
  task automatic semw(input logic [7:0] i, input logic [6:0] r);
    @(negedge core_clk);
    sem_wr_en = 1'b1;
    sem_wr_index = i;
    sem_wr_reg = r;
    @(negedge core_clk);
    sem_wr_en = 1'b0;
  endtask
  // Bounded wait for the end-of-clause pulse
  task automatic wait_done();
    int t;
    t = 0;
    while (clause_done !== 1'b1 && t < 100) begin
      @(negedge core_clk);
      t++;
    end
    check("clause_done", clause_done, 1'b1);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Every issued fetch against the oldest expectation
  always @(negedge core_clk) begin
    if (fetch_valid === 1'b1) begin
      n_fetch++;
      if (expq.size() == 0) check("fetch_extra", 1'b1, 1'b0);
      else check("fetch_fields", {source_register_index, source_element_select,
        destination_register_index, destination_element_selects, element_write_enable,
        constant_buffer_select, constant_bank_stage, fetch_offset}, expq.pop_front());
    end
  end
  // Watchdog, well beyond the expected run
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    complete_run();
  end
  initial begin
    rows[0] = '{OPV, ST_V, 8'h05, mk(0, 2, 0, 7'h10, 8'h3A, 8'h20, 12'hF60, 0, 16'h1234),
                7'h10, 7'h20, ST_V};
    rows[1] = '{OPT, ST_E, 8'h85, mk(0, 3, 1, 7'h7E, 8'hFF, 8'h90, 12'h688, 1, 16'hFFFF),
                7'h03, 7'h15, ST_G};
    rows[2] = '{OPV, ST_G, 8'h0A, mk(1, 1, 1, 7'h01, 8'h00, 8'hC8, 12'hFFF, 1, 16'h0000),
                7'h0B, 7'h44, ST_V};
    rows[3] = '{OPT, ST_P, 8'h01, mk(0, 0, 0, 7'h05, 8'h01, 8'hFF, 12'h000, 1, 16'h0001),
                7'h05, 7'h00, ST_P};
    rows[4] = '{OPV, ST_E, 8'h00, mk(1, 2, 0, 7'h22, 8'h80, 8'h00, 12'hDB6, 0, 16'h8000),
                7'h22, 7'h12, ST_E};
    rows[5] = '{OPV, ST_G, 8'h33, mk(1, 0, 0, 7'h7F, 8'h10, 8'hFF, 12'h000, 0, 16'h0100),
                7'h7F, 7'h7F, ST_G};
    repeat (12) @(negedge core_clk);
    // Reset values
    check("reset_outs", {busy, clause_done, fetch_valid, instr_ready, constant_bank_stage},
          6'h00);
    srst = 1'b0;
    semw(8'hC8, 7'h44);
    semw(8'h00, 7'h12);
    semw(8'hFF, 7'h7F);
    // Ordinary cases, one single-fetch clause per row
    foreach (rows[r]) begin
      seq_u.prog[0] = rows[r].w;
      expq.push_back(ex(rows[r].w, rows[r].esrc, rows[r].edst, rows[r].estg));
      seq_u.run(rows[r].op, 5'h01, 1'b1, rows[r].stg, rows[r].li, r % 2);
      wait_done();
    end
    // Reset in mid-clause: the clause is abandoned and nothing is issued
    f0 = n_fetch;
    fork
      seq_u.run(OPV, 5'h03, 1'b1, ST_V, 8'h00, 4);
      begin
        repeat (3) @(negedge core_clk);
        check("mid_busy", busy, 1'b1);
        srst = 1'b1;
        repeat (2) @(negedge core_clk);
        check("mid_reset", {busy, clause_done, fetch_valid, instr_ready}, 4'h0);
        srst = 1'b0;
      end
    join
    // Sequencer gave up waiting; no fetch and no end pulse may follow
    check("mid_reset_after", {clause_done, busy, 32'(n_fetch - f0)}, 34'h0);
    // Longest clause, back to back, offsets in order
    for (int k = 0; k < 16; k++) begin
      seq_u.prog[k] = mk(0, 1, 0, 7'h10, 8'h07, 8'h20, 12'h688, 0, 16'(k));
      expq.push_back(ex(seq_u.prog[k], 7'h10, 7'h20, ST_V));
    end
    f0 = n_fetch;
    seq_u.run(OPV, 5'h10, 1'b1, ST_V, 8'h00, 0);
    wait_done();
    check("long_count", n_fetch - f0, 16);
    // False launch condition: instructions consumed, nothing issued
    f0 = n_fetch;
    seq_u.run(OPT, 5'h03, 1'b0, ST_G, 8'h00, 2);
    wait_done();
    check("cond_false", n_fetch - f0, 0);
    // Other clause kind never starts
    seq_u.run(vfcd_pkg::VFCD_OP_OTHER, 5'h00, 1'b1, ST_V, 8'h00, 0);
    check("other_op", {busy, clause_done}, 2'b00);
    // Empty clause still completes
    seq_u.run(OPV, 5'h00, 1'b1, ST_V, 8'h00, 0);
    wait_done();
    check("queue_left", expq.size(), 0);
    complete_run();
  end
endmodule
